// *** core/dfa_cfg.svh ***
// Purpose: Named constants for the dynamic floor adjust interval block.
// Assumes: Included by bare name from the package and every design module.
// Notes: Register indices are word indices; the byte address is four times the index.
`ifndef DFA_CFG_SVH
`define DFA_CFG_SVH

// Register word indices on the bus.
`define DFA_IDX_INTV1 8'h36
`define DFA_IDX_INTV2 8'h37
`define DFA_IDX_CFG 8'h40
`define DFA_IDX_STAT 8'h41

// Address slicing: word index bits and the upper bits that must be zero.
`define DFA_IDX_HI 9
`define DFA_IDX_LO 2
`define DFA_ADDR_HI 31
`define DFA_ADDR_UP_LO 10
`define DFA_ADDR_UP_ZERO 22'h000000

// Reset values.
`define DFA_INTV1_RST 8'h00
`define DFA_INTV2_RST 8'h00
`define DFA_RDATA_RST 32'h00000000

// Field positions in the interval registers.
`define DFA_R1_LSB 0
`define DFA_LOC_LSB 3
`define DFA_R2LO_LSB 6
`define DFA_R2HI_BIT 0
`define DFA_EN_LSB 5
`define DFA_R2LO_W 2
`define DFA_EN_LOC_BIT 6
`define DFA_EN_R2_BIT 7
`define DFA_INTV2_MASK 8'hE1

// Field positions in the configuration and status registers.
`define DFA_LOCK_BIT 1
`define DFA_STAT_INC_LSB 3
`define DFA_STAT_LOCK_BIT 6

// Widths and counts.
`define DFA_NCH 3
`define DFA_CODE_W 3
`define DFA_CNT_W 12
`define DFA_DATA_W 32
`define DFA_REG_W 8

// Interval timing in monitoring cycles: decrease base, increase is double.
`define DFA_DEC_BASE 12'h008
`define DFA_INC_BASE 12'h010
`define DFA_CNT_MAX 12'hFFF
`define DFA_CNT_ONE 12'h001
`define DFA_CNT_ZERO 12'h000

// Transfer type bit that marks NONSEQ or SEQ.
`define DFA_HTRANS_ACT 1

`endif

// *** core/dfa_pkg.sv ***
// Purpose: Types shared by the dynamic floor adjust interval block.
// Assumes: Constants come from dfa_cfg.svh.
// Notes: Structs carry signals that travel together.
`include "dfa_cfg.svh"

package dfa_pkg;

	// Pending bus data phase captured from the address phase.
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] idx;
	} dfa_ahb_req_t;

	// Per-channel control seen by one interval timer.
	typedef struct packed {
		logic [`DFA_CODE_W-1:0] code;
		logic enable;
		logic req_dec;
		logic req_inc;
	} dfa_chan_ctl_t;

	// Per-channel adjustment grant pulses.
	typedef struct packed {
		logic dec;
		logic inc;
	} dfa_grant_t;

endpackage

// *** core/dfa_thresh.sv ***
// Purpose: Turn a three-bit interval code into decrease and increase thresholds.
// Assumes: Thresholds are counted in monitoring cycles.
// Notes: Pure combinational decode; the increase wait is always twice the decrease wait.
`timescale 1ns/1ns
`include "dfa_cfg.svh"

module dfa_thresh
	import dfa_pkg::*;
(
	input wire logic [`DFA_CODE_W-1:0] code,
	output logic [`DFA_CNT_W-1:0] dec_thr,
	output logic [`DFA_CNT_W-1:0] inc_thr
);

	// Shift the base by the code; code 7 gives 1024 and 2048, which fit in twelve bits.
	always_comb begin
		dec_thr = `DFA_DEC_BASE << code;
		inc_thr = `DFA_INC_BASE << code;
	end

endmodule // dfa_thresh

// *** core/dfa_chan_timer.sv ***
// Purpose: One channel's monitoring-cycle interval counter and adjustment grant.
// Assumes: tick is a one-cycle pulse per monitoring cycle; requests are levels.
// Notes: Decrease wins when both directions are requested in the same cycle.
`timescale 1ns/1ns
`include "dfa_cfg.svh"

module dfa_chan_timer
	import dfa_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic tick,
	input wire dfa_chan_ctl_t ctl,
	input wire logic [`DFA_CNT_W-1:0] dec_thr,
	input wire logic [`DFA_CNT_W-1:0] inc_thr,
	output dfa_grant_t grant,
	output logic dec_ready,
	output logic inc_ready
);

	logic [`DFA_CNT_W-1:0] cnt_r;
	logic [`DFA_CNT_W-1:0] cnt_nxt;
	dfa_grant_t grant_r;
	dfa_grant_t grant_nxt;

	// Readiness compares the elapsed whole monitoring cycles to each threshold.
	assign dec_ready = (cnt_r >= dec_thr);
	assign inc_ready = (cnt_r >= inc_thr);
	assign grant = grant_r;

	// The counter saturates so a long idle channel stays ready instead of wrapping.
	always_comb begin
		cnt_nxt = cnt_r;
		grant_nxt = '0;
		if (tick && cnt_r != `DFA_CNT_MAX) begin
			cnt_nxt = cnt_r + `DFA_CNT_ONE;
		end
		if (ctl.enable) begin
			if (ctl.req_dec && dec_ready) begin
				grant_nxt.dec = 1'b1;
				cnt_nxt = `DFA_CNT_ZERO;
			end else if (ctl.req_inc && inc_ready) begin
				grant_nxt.inc = 1'b1;
				cnt_nxt = `DFA_CNT_ZERO;
			end
		end
	end

	// Registers only; reset starts every channel with a fresh interval.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cnt_r <= `DFA_CNT_ZERO;
			grant_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
			grant_r <= grant_nxt;
		end
	end

endmodule // dfa_chan_timer

// *** core/dfa_top.sv ***
// Purpose: Interval register and per-channel pacing of fan start temperature adjustments.
// Assumes: AHB-Lite single word transfers; monitor_tick pulses once per monitoring cycle.
// Notes: Zero wait state slave; reads see a write that completes in the same cycle.
// Notes: hsize is not decoded; every register is one aligned word with its data in bits 7:0.
// Notes: A tick that lands on a grant cycle is dropped, so every interval starts from zero.
// Assumes: Software sets the lock last; nothing but reset clears it.
// Function
// - Interval control register clears to zero at reset, shortest code everywhere.
// - After the lock bit is set, interval register writes are discarded.
// - Bits 2:0 hold remote 1 interval code setting its adjustment spacing.
// - Code n waits 8 shl n cycles to decrease, twice that to increase.
// - Code 111 waits 1024 cycles to decrease and 2048 to increase.
// - Bits 5:3 hold the local channel code with the same encoding.
// - Intervals are counted in whole monitoring cycles, eight per second.
// - Remote 2 code is assembled from bits in two registers, same encoding.
// - Adjustments are granted only while the channel's enable bit is one.
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ns
`include "dfa_cfg.svh"

module dfa_top
	import dfa_pkg::*;
(
	// Clock and synchronous reset.
	input wire logic clk_sys,
	input wire logic srst,
	// AHB-Lite slave port; hsize is accepted but not decoded.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Monitoring cycle timebase and per-channel adjustment handshake.
	input wire logic monitor_tick,
	input wire logic [`DFA_NCH-1:0] adjust_req_dec,
	input wire logic [`DFA_NCH-1:0] adjust_req_inc,
	output logic [`DFA_NCH-1:0] adjust_dec,
	output logic [`DFA_NCH-1:0] adjust_inc
);

	// Register file state.
	// The lock flag lives in the configuration word and only reset clears it.
	logic [`DFA_REG_W-1:0] floor_adjust_interval_ctrl_r;
	logic [`DFA_REG_W-1:0] floor_adjust_interval_ctrl_nxt;
	logic [`DFA_REG_W-1:0] floor_adjust_enable_ctrl_r;
	logic [`DFA_REG_W-1:0] floor_adjust_enable_ctrl_nxt;
	logic lock_r;
	logic lock_nxt;

	// Bus state.
	// The data phase fields are captured when an address phase is taken.
	dfa_ahb_req_t dph_r;
	dfa_ahb_req_t dph_nxt;
	logic [`DFA_DATA_W-1:0] hrdata_r;
	logic [`DFA_DATA_W-1:0] hrdata_nxt;
	logic hreadyout_r;
	logic hresp_r;
	logic hreadyout_nxt;
	logic hresp_nxt;

	// Decode helpers; aph is the address phase, dph the data phase one cycle later.
	logic aph_take;
	logic wr_intv1;
	logic wr_intv2;
	logic wr_cfg;
	logic [`DFA_DATA_W-1:0] stat_word;
	logic [`DFA_DATA_W-1:0] rd_word;
	logic [7:0] aph_idx;
	logic aph_mapped;
	logic wr_now;
	logic [`DFA_REG_W-1:0] wr_byte;

	// Channel side.
	// Decoded codes and enables, then per-channel readiness and grants.
	logic [`DFA_CODE_W-1:0] remote1_adjust_interval;
	logic [`DFA_CODE_W-1:0] local_adjust_interval;
	logic [`DFA_CODE_W-1:0] remote2_adjust_interval;
	logic remote1_dynamic_floor_enable;
	logic local_dynamic_floor_enable;
	logic remote2_dynamic_floor_enable;
	logic [`DFA_CODE_W-1:0] ch_code [`DFA_NCH];
	logic [`DFA_NCH-1:0] ch_en;
	logic [`DFA_NCH-1:0] ch_dec_ready;
	logic [`DFA_NCH-1:0] ch_inc_ready;
	dfa_grant_t ch_grant [`DFA_NCH];

	// Every bus output is a flop, so the slave adds no combinational path to the bus.
	assign hrdata = hrdata_r;
	assign hreadyout = hreadyout_r;
	assign hresp = hresp_r;

	// Address phase is taken when selected, active, and the bus is ready.
	assign aph_take = hsel && htrans[`DFA_HTRANS_ACT] && hready;
	assign aph_idx = haddr[`DFA_IDX_HI:`DFA_IDX_LO];

	// A data phase write is pending when the captured phase was a mapped write.
	// Only the low byte of a write matters; the upper bits are ignored, not checked.
	assign wr_now = dph_r.valid && dph_r.write;
	assign wr_byte = hwdata[`DFA_REG_W-1:0];

	// Only the word indices of the four registers decode; all else is unmapped.
	// Upper address bits must be zero, so the map does not alias above the first
	// kilobyte; an access there still completes with an OKAY response.
	always_comb begin
		aph_mapped = 1'b0;
		if (haddr[`DFA_ADDR_HI:`DFA_ADDR_UP_LO] != `DFA_ADDR_UP_ZERO) begin
			aph_mapped = 1'b0;
		end else if (aph_idx == `DFA_IDX_INTV1) begin
			aph_mapped = 1'b1;
		end else if (aph_idx == `DFA_IDX_INTV2) begin
			aph_mapped = 1'b1;
		end else if (aph_idx == `DFA_IDX_CFG) begin
			aph_mapped = 1'b1;
		end else if (aph_idx == `DFA_IDX_STAT) begin
			aph_mapped = 1'b1;
		end
	end

	// Write strobes for the data phase; only one register is addressed at a time.
	always_comb begin
		wr_intv1 = 1'b0;
		wr_intv2 = 1'b0;
		wr_cfg = 1'b0;
		if (!wr_now) begin
			wr_intv1 = 1'b0;
		end else if (dph_r.idx == `DFA_IDX_INTV1) begin
			wr_intv1 = 1'b1;
		end else if (dph_r.idx == `DFA_IDX_INTV2) begin
			wr_intv2 = 1'b1;
		end else if (dph_r.idx == `DFA_IDX_CFG) begin
			wr_cfg = 1'b1;
		end
	end

	// Write commit in the data phase; the lock blocks both interval registers.
	// The lock is sticky until reset so a stray write cannot reopen the map.
	// Writes land at the end of the data phase, the only cycle in which hwdata is valid.
	always_comb begin
		floor_adjust_interval_ctrl_nxt = floor_adjust_interval_ctrl_r;
		floor_adjust_enable_ctrl_nxt = floor_adjust_enable_ctrl_r;
		lock_nxt = lock_r;
		if (wr_intv1 && !lock_r) begin
			floor_adjust_interval_ctrl_nxt = wr_byte;
		end
		if (wr_intv2 && !lock_r) begin
			floor_adjust_enable_ctrl_nxt = wr_byte & `DFA_INTV2_MASK;
		end
		if (wr_cfg && wr_byte[`DFA_LOCK_BIT]) begin
			lock_nxt = 1'b1;
		end
	end

	// Register storage; both interval registers power up at zero.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			floor_adjust_interval_ctrl_r <= `DFA_INTV1_RST;
			floor_adjust_enable_ctrl_r <= `DFA_INTV2_RST;
			lock_r <= 1'b0;
		end else begin
			floor_adjust_interval_ctrl_r <= floor_adjust_interval_ctrl_nxt;
			floor_adjust_enable_ctrl_r <= floor_adjust_enable_ctrl_nxt;
			lock_r <= lock_nxt;
		end
	end

	// Status word: readiness of every channel and the lock state.
	// It is a snapshot taken with the address, so it may be stale by the data phase.
	always_comb begin
		stat_word = '0;
		stat_word[`DFA_NCH-1:0] = ch_dec_ready;
		stat_word[`DFA_STAT_INC_LSB +: `DFA_NCH] = ch_inc_ready;
		stat_word[`DFA_STAT_LOCK_BIT] = lock_r;
	end

	// Read word for the addressed register, formed from next values except the status word.
	// A read right behind a write to the same register thus returns the new byte.
	always_comb begin
		rd_word = '0;
		if (!aph_mapped) begin
			rd_word = '0;
		end else if (aph_idx == `DFA_IDX_INTV1) begin
			rd_word[`DFA_REG_W-1:0] = floor_adjust_interval_ctrl_nxt;
		end else if (aph_idx == `DFA_IDX_INTV2) begin
			rd_word[`DFA_REG_W-1:0] = floor_adjust_enable_ctrl_nxt;
		end else if (aph_idx == `DFA_IDX_CFG) begin
			rd_word[`DFA_LOCK_BIT] = lock_nxt;
		end else if (aph_idx == `DFA_IDX_STAT) begin
			rd_word = stat_word;
		end
	end

	// Capture the data phase and the read data when an address phase is taken.
	// Unmapped reads return zero with an OKAY response.
	always_comb begin
		dph_nxt = '0;
		hrdata_nxt = hrdata_r;
		if (aph_take) begin
			dph_nxt.valid = aph_mapped;
			dph_nxt.write = hwrite;
			dph_nxt.idx = aph_idx;
			hrdata_nxt = '0;
			if (!hwrite) begin
				hrdata_nxt = rd_word;
			end
		end
	end

	// Wait and response next values; this slave has no reason to stall or fail.
	always_comb begin
		hreadyout_nxt = 1'b1;
		hresp_nxt = 1'b0;
	end

	// Bus registers; the slave never stretches a transfer and never errors.
	// hreadyout stays high through reset so a master never hangs on this slave.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			dph_r <= '0;
			hrdata_r <= `DFA_RDATA_RST;
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
		end else begin
			dph_r <= dph_nxt;
			hrdata_r <= hrdata_nxt;
			hreadyout_r <= hreadyout_nxt;
			hresp_r <= hresp_nxt;
		end
	end

	// Field extraction: remote 2 joins its high bit from the second register.
	// The split field means software writes both registers to change that code,
	// and the timer may see a half-updated code between the two writes.
	assign remote1_adjust_interval =
		floor_adjust_interval_ctrl_r[`DFA_R1_LSB +: `DFA_CODE_W];
	assign local_adjust_interval =
		floor_adjust_interval_ctrl_r[`DFA_LOC_LSB +: `DFA_CODE_W];
	assign remote2_adjust_interval = {floor_adjust_enable_ctrl_r[`DFA_R2HI_BIT],
		floor_adjust_interval_ctrl_r[`DFA_R2LO_LSB +: `DFA_R2LO_W]};

	// Enable bits sit in the second register, one per channel.
	assign remote1_dynamic_floor_enable = floor_adjust_enable_ctrl_r[`DFA_EN_LSB];
	assign local_dynamic_floor_enable = floor_adjust_enable_ctrl_r[`DFA_EN_LOC_BIT];
	assign remote2_dynamic_floor_enable = floor_adjust_enable_ctrl_r[`DFA_EN_R2_BIT];

	// Channel order is remote 1, local, remote 2.
	// This order sets the bit positions of the request, grant and status vectors.
	assign ch_code[0] = remote1_adjust_interval;
	assign ch_code[1] = local_adjust_interval;
	assign ch_code[2] = remote2_adjust_interval;
	assign ch_en = {remote2_dynamic_floor_enable, local_dynamic_floor_enable,
		remote1_dynamic_floor_enable};

	// One decoder and one interval timer per channel.
	// A disabled channel keeps counting but is never granted, so setting its
	// enable later can release an adjustment on the very next cycle.
	for (genvar ch = 0; ch < `DFA_NCH; ch++) begin : g_chan
		logic [`DFA_CNT_W-1:0] dec_thr;
		logic [`DFA_CNT_W-1:0] inc_thr;
		dfa_chan_ctl_t ctl;

		// Pack this channel's code, enable and request levels for its timer.
		assign ctl.code = ch_code[ch];
		assign ctl.enable = ch_en[ch];
		assign ctl.req_dec = adjust_req_dec[ch];
		assign ctl.req_inc = adjust_req_inc[ch];

		// Thresholds are a pure decode of the code; a new code applies at once.
		dfa_thresh u_thresh (
			.code(ctl.code),
			.dec_thr(dec_thr),
			.inc_thr(inc_thr)
		);

		// The timer owns the counter, so a grant and its counter restart share one edge.
		dfa_chan_timer u_timer (
			.clk_sys(clk_sys),
			.srst(srst),
			.tick(monitor_tick),
			.ctl(ctl),
			.dec_thr(dec_thr),
			.inc_thr(inc_thr),
			.grant(ch_grant[ch]),
			.dec_ready(ch_dec_ready[ch]),
			.inc_ready(ch_inc_ready[ch])
		);

		// Grants leave the timers as registered pulses.
		// No extra flop here: the timer's grant register already feeds the pin.
		assign adjust_dec[ch] = ch_grant[ch].dec;
		assign adjust_inc[ch] = ch_grant[ch].inc;
	end

endmodule // dfa_top

// *** tb/dfa_properties.sv ***
// Purpose: Port-level properties of the interval pacing block.
// Assumes: One clock domain; srst is synchronous and active high.
// Notes: Grant spacing is tracked for remote 1 only, to keep the helper small.
`timescale 1ns/1ns
`include "dfa_cfg.svh"

module dfa_properties (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic monitor_tick,
	input wire logic [`DFA_NCH-1:0] adjust_req_dec,
	input wire logic [`DFA_NCH-1:0] adjust_req_inc,
	input wire logic [`DFA_NCH-1:0] adjust_dec,
	input wire logic [`DFA_NCH-1:0] adjust_inc
);
	logic [11:0] gap_r;
	logic [11:0] gap_nxt;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);

	// Ticks since the last remote 1 grant; it saturates so a long idle cannot wrap.
	always_comb begin
		gap_nxt = gap_r + {11'h000, monitor_tick};
		if (adjust_dec[0] | adjust_inc[0])
			gap_nxt = {11'h000, monitor_tick};
		else if (gap_r == 12'hFFF)
			gap_nxt = gap_r;
	end

	// Register the tick count.
	always_ff @(posedge clk_sys) begin
		gap_r <= srst ? 12'h000 : gap_nxt;
	end

	sequence grant_seen;
		(adjust_dec | adjust_inc) != 3'h0;
	endsequence

	hready_one_a: assert property (hreadyout) else $error("hreadyout low");
	resp_okay_a: assert property (!hresp) else $error("hresp not OKAY");
	reset_quiet_a: assert property ($fell(srst) |-> hrdata == 32'h0 &&
		adjust_dec == 3'h0 && adjust_inc == 3'h0) else $error("outputs busy after reset");
	grant_pulse_a: assert property (grant_seen |=>
		((adjust_dec | adjust_inc) & $past(adjust_dec | adjust_inc)) == 3'h0)
		else $error("grant longer than one cycle");
	dec_cause_a: assert property ((adjust_dec & ~$past(adjust_req_dec)) == 3'h0)
		else $error("decrease without request");
	inc_cause_a: assert property ((adjust_inc & ~$past(adjust_req_inc)) == 3'h0)
		else $error("increase without request");
	dec_wins_a: assert property ((adjust_inc & $past(adjust_req_dec)) == 3'h0)
		else $error("increase beat decrease");
	dec_space_a: assert property (adjust_dec[0] |-> $past(gap_r) >= 12'h008)
		else $error("decrease too soon");
	inc_space_a: assert property (adjust_inc[0] |-> $past(gap_r) >= 12'h010)
		else $error("increase too soon");
endmodule // dfa_properties

bind dfa_top dfa_properties dfa_properties_inst (.clk_sys(clk_sys), .srst(srst),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .monitor_tick(monitor_tick),
	.adjust_req_dec(adjust_req_dec), .adjust_req_inc(adjust_req_inc),
	.adjust_dec(adjust_dec), .adjust_inc(adjust_inc));

// *** tb/dfa_top_tb.sv ***
// Purpose: Self-checking bench for the interval register and grant pacing.
// Assumes: Zero wait state slave; ticks every second clock while running.
// Notes: Ticks stay off while registers are set, so counts start from reset.
`timescale 1ns/1ns
`include "dfa_cfg.svh"

module dfa_top_tb;
	logic clk_sys = 1'h0;
	logic srst = 1'h1;
	logic hsel = 1'h0;
	logic hwrite = 1'h0;
	logic monitor_tick = 1'h0;
	logic run = 1'h0;
	logic rd_ph = 1'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout;
	logic hresp;
	logic [2:0] adjust_req_dec = 3'h0;
	logic [2:0] adjust_req_inc = 3'h0;
	logic [2:0] adjust_dec;
	logic [2:0] adjust_inc;
	logic [2:0] c0;
	logic [2:0] c1;
	logic [11:0] m [3];
	logic [31:0] rq [$];
	logic [31:0] gq [3][$];
	int n_mismatch = 0;
	int n_compared = 0;

	dfa_top dfa_top_inst (.clk_sys, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .monitor_tick,
		.adjust_req_dec, .adjust_req_inc, .adjust_dec, .adjust_inc);

	// Free-running clock and a tick on every second edge while enabled.
	initial forever #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) monitor_tick <= run & ~monitor_tick;

	function automatic logic [31:0] gv(input logic d, input logic i, input logic [11:0] c);
		return {18'h0, d, i, c};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One single transfer; every signal is held until hready is sampled high.
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'h1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge clk_sys);
		while (!hreadyout) @(posedge clk_sys);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph <= !w;
		@(posedge clk_sys);
		while (!hreadyout) @(posedge clk_sys);
		rd_ph <= 1'h0;
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		rq.push_back(exp);
		bus(a, 1'h0, 32'h0);
	endtask

	// Codes with random junk above the byte, then enables for remote 1 and local.
	task automatic cfg(input logic [2:0] a, input logic [2:0] b);
		bus(32'hD8, 1'h1, ($urandom & 32'hFFFFFF00) | {26'h0, b, a});
		bus(32'hDC, 1'h1, 32'h60);
	endtask

	// Remote 1 asks both ways, or only up; local only up; remote 2 both ways while disabled.
	task automatic go(input logic [2:0] a, input logic [2:0] b, input int n, input logic up);
		repeat (n) begin
			if (up)
				gq[0].push_back(gv(1'h0, 1'h1, 12'(16 << a)));
			else
				gq[0].push_back(gv(1'h1, 1'h0, 12'(8 << a)));
			gq[1].push_back(gv(1'h0, 1'h1, 12'(16 << b)));
		end
		adjust_req_dec <= up ? 3'h4 : 3'h5;
		adjust_req_inc <= 3'h7;
		run <= 1'h1;
		while (gq[0].size() + gq[1].size() != 0) @(posedge clk_sys);
		run <= 1'h0;
		adjust_req_dec <= 3'h0;
		adjust_req_inc <= 3'h0;
	endtask

	// Watches read data and grants; a grant on a drained channel is only judged on remote 2.
	always @(posedge clk_sys) begin
		if (rd_ph && hreadyout)
			chk(hrdata, rq.pop_front(), "hrdata");
		for (int ch = 0; ch < 3; ch++) begin
			if (srst)
				m[ch] = 12'h000;
			else if (adjust_dec[ch] | adjust_inc[ch]) begin
				if (ch == 2 || gq[ch].size() != 0)
					chk(gv(adjust_dec[ch], adjust_inc[ch], m[ch]),
						ch == 2 ? 32'h0 : gq[ch].pop_front(), "grant");
				m[ch] = {11'h000, monitor_tick};
			end else
				m[ch] = m[ch] + {11'h000, monitor_tick};
		end
	end

	task automatic test_done;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Cuts a hang well beyond the longest expected run.
	initial begin
		repeat (40000) @(posedge clk_sys);
		n_mismatch++;
		test_done;
	end

	initial begin
		void'($urandom(32'hBB08A439));
		c0 = 3'($urandom % 7);
		c1 = 3'($urandom % 7);
		repeat (2) @(posedge clk_sys);
		srst <= 1'h0;
		@(posedge clk_sys);
		rd(32'hD8, 32'h0);
		rd(32'hDC, 32'h0);
		cfg(c0, c1);
		rd(32'hD8, {26'h0, c1, c0});
		rd(32'h200, 32'h0);
		go(c0, c1, 2, 1'h0);
		srst <= 1'h1;
		repeat (2) @(posedge clk_sys);
		srst <= 1'h0;
		@(posedge clk_sys);
		cfg(3'h7, 3'h7);
		bus(32'h100, 1'h1, 32'h2);
		rd(32'h100, 32'h2);
		rd(32'h104, 32'h40);
		bus(32'hD8, 1'h1, 32'h0);
		rd(32'hD8, 32'h3F);
		bus(32'hDC, 1'h1, 32'h0);
		rd(32'hDC, 32'h60);
		go(3'h7, 3'h7, 1, 1'h1);
		test_done;
	end
endmodule // dfa_top_tb
